/* rsq_cfg.svh */
// Offsets, field positions, reset values and sizes of the RAM sweep address sequencer.
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

`define RSQ_BUS_AW        8
`define RSQ_OFF_CTRL      8'h00
`define RSQ_OFF_STATUS    8'h04
`define RSQ_SEG_PAGE      3'h1

`define RSQ_CTRL_RAM_EN   31
`define RSQ_CTRL_DEST     30
`define RSQ_CTRL_IPC_HI   29
`define RSQ_CTRL_IPC_LO   27
`define RSQ_CTRL_RST      32'h0000_0000

`define RSQ_SEG_RATE_HI   15
`define RSQ_SEG_RATE_LO   0
`define RSQ_SEG_MODE_HI   7
`define RSQ_SEG_MODE_LO   5
`define RSQ_SEG_BEG_HI    17
`define RSQ_SEG_BEG_LO    8
`define RSQ_SEG_FIN_HI    27
`define RSQ_SEG_FIN_LO    18
`define RSQ_SEG_RST       32'h0000_0000

`define RSQ_IPC_OFF       3'h0
`define RSQ_IPC_BAD       3'h7
`define RSQ_TIMER_ONE     16'h0001
`define RSQ_ADDR_ONE      10'h001

`endif

/* rsq_pkg.sv */
// Types shared by the RAM sweep address sequencer files.
package rsq_pkg;

  typedef logic [9:0]  rsq_addr_t;
  typedef logic [15:0] rsq_rate_t;

  typedef struct packed {
    rsq_rate_t rate;
    rsq_addr_t final_addr;
    rsq_addr_t begin_addr;
    logic [2:0] mode;
  } rsq_seg_t;

  typedef enum logic [2:0] {
    M_DIRECT  = 3'b000,
    M_RAMP_UP = 3'b001,
    M_BIDIR   = 3'b010,
    M_CBIDIR  = 3'b011,
    M_RECIRC  = 3'b100
  } rsq_mode_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_LOAD = 2'b01,
    SW_RUN  = 2'b10,
    SW_STOP = 2'b11
  } rsq_state_t;

endpackage

/* rsq_seg_mem.sv */
// Active segment table: bulk loaded on update, one registered read port.
`timescale 1ns/1ps
module rsq_seg_mem (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic                    load,
  input  wire rsq_pkg::rsq_seg_t [3:0] load_data,
  input  wire logic [1:0]              rd_idx,
  output      rsq_pkg::rsq_seg_t       rd_data
);
  import rsq_pkg::*;

  rsq_seg_t mem_q [4];
  rsq_seg_t rd_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce && load) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= load_data[i];
      end
    end
  end

  // The read sees the table one cycle after a load, never a mix of old and new words.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= '0;
    end else if (ce) begin
      rd_q <= mem_q[rd_idx];
    end
  end

  assign rd_data = rd_q;

endmodule // rsq_seg_mem

/* rsq_sequencer.sv */
// RAM sweep address sequencer with profile pins, update strobe and register port.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_sequencer (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic                    profile_select_low,
  input  wire logic                    profile_select_high,
  input  wire logic                    update_strobe,
  input  wire logic [`RSQ_BUS_AW-1:0]  bus_addr,
  input  wire logic [31:0]             bus_wdata,
  input  wire logic                    bus_write,
  input  wire logic                    bus_read,
  output      logic [31:0]             bus_rdata,
  output      rsq_pkg::rsq_addr_t      ram_addr,
  output      logic                    ram_dest_phase,
  output      logic                    sweep_stopped
);
  import rsq_pkg::*;

  function automatic rsq_addr_t addr_inc(input rsq_addr_t a);
    return a + `RSQ_ADDR_ONE;
  endfunction

  function automatic rsq_addr_t addr_dec(input rsq_addr_t a);
    return a - `RSQ_ADDR_ONE;
  endfunction

  function automatic rsq_mode_t decode_mode(input logic [2:0] c);
    unique case (c)
      3'b001:  return M_RAMP_UP;
      3'b010:  return M_BIDIR;
      3'b011:  return M_CBIDIR;
      3'b100:  return M_RECIRC;
      default: return M_DIRECT;
    endcase
  endfunction

  function automatic logic seg_hit(input logic [`RSQ_BUS_AW-1:0] a);
    return a[7:5] == `RSQ_SEG_PAGE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  logic [1:0]  ps_s1_q;
  logic [1:0]  ps_s2_q;
  logic [1:0]  ps_s3_q;
  logic        upd_s1_q;
  logic        upd_s2_q;
  logic        upd_s3_q;
  logic        upd_rise;
  logic        dir_chg;
  logic        ps_chg;

  // Only the second and third stages feed logic; the first may be metastable.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ps_s1_q  <= 2'h0;
      ps_s2_q  <= 2'h0;
      ps_s3_q  <= 2'h0;
      upd_s1_q <= 1'b0;
      upd_s2_q <= 1'b0;
      upd_s3_q <= 1'b0;
    end else if (ce) begin
      ps_s1_q  <= {profile_select_high, profile_select_low};
      ps_s2_q  <= ps_s1_q;
      ps_s3_q  <= ps_s2_q;
      upd_s1_q <= update_strobe;
      upd_s2_q <= upd_s1_q;
      upd_s3_q <= upd_s2_q;
    end
  end

  assign upd_rise = upd_s2_q & ~upd_s3_q;
  assign dir_chg  = ps_s2_q[0] ^ ps_s3_q[0];
  assign ps_chg   = |(ps_s2_q ^ ps_s3_q);

  ////////////////////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_buf_q;
  logic [31:0] ctrl_act_q;
  logic [31:0] seg_buf_q [8];
  logic [2:0]  mode0_q;
  rsq_seg_t [3:0] load_tab;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_buf_q <= `RSQ_CTRL_RST;
      for (int i = 0; i < 8; i++) begin
        seg_buf_q[i] <= `RSQ_SEG_RST;
      end
    end else if (ce && bus_write) begin
      if (bus_addr == `RSQ_OFF_CTRL) begin
        ctrl_buf_q <= bus_wdata & 32'hf800_0000;
      end
      if (seg_hit(bus_addr)) begin
        seg_buf_q[bus_addr[4:2]] <= bus_wdata & 32'h0fff_ffff;
      end
    end
  end

  // Pin activity never reaches the active copy; only the strobe edge does.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_act_q <= `RSQ_CTRL_RST;
      mode0_q    <= 3'h0;
    end else if (ce && upd_rise) begin
      ctrl_act_q <= ctrl_buf_q;
      mode0_q    <= seg_buf_q[1][`RSQ_SEG_MODE_HI:`RSQ_SEG_MODE_LO];
    end
  end

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      load_tab[p].rate       = seg_buf_q[2*p][`RSQ_SEG_RATE_HI:`RSQ_SEG_RATE_LO];
      load_tab[p].final_addr = seg_buf_q[2*p+1][`RSQ_SEG_FIN_HI:`RSQ_SEG_FIN_LO];
      load_tab[p].begin_addr = seg_buf_q[2*p+1][`RSQ_SEG_BEG_HI:`RSQ_SEG_BEG_LO];
      load_tab[p].mode       = seg_buf_q[2*p+1][`RSQ_SEG_MODE_HI:`RSQ_SEG_MODE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  logic        ram_en;
  logic [2:0]  ipc;
  logic        int_act;
  logic        bidir;
  logic [1:0]  last_prof;
  logic [1:0]  seq_prof_q;
  logic [1:0]  mem_idx;
  rsq_seg_t    seg_rd;
  rsq_mode_t   cur_mode;

  assign ram_en    = ctrl_act_q[`RSQ_CTRL_RAM_EN];
  assign ipc       = ctrl_act_q[`RSQ_CTRL_IPC_HI:`RSQ_CTRL_IPC_LO];
  assign int_act   = ram_en && (ipc != `RSQ_IPC_OFF) && (ipc != `RSQ_IPC_BAD);
  assign last_prof = ipc[2] ? ipc[1:0] + 2'h1 : ipc[1:0];
  assign bidir     = ram_en && !int_act && (decode_mode(mode0_q) == M_BIDIR);
  assign mem_idx   = int_act ? seq_prof_q : (bidir ? 2'h0 : ps_s3_q);
  assign cur_mode  = int_act ? M_RAMP_UP : (bidir ? M_BIDIR : decode_mode(seg_rd.mode));

  rsq_seg_mem u_seg_mem (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .load      (upd_rise),
    .load_data (load_tab),
    .rd_idx    (mem_idx),
    .rd_data   (seg_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  rsq_state_t state_q;
  logic       wait_q;
  rsq_addr_t  addr_q;
  rsq_addr_t  addr_d;
  logic       up_q;
  logic       up_d;
  rsq_rate_t  timer_q;
  logic       tick;
  logic       at_final;
  logic       seq_end;
  logic       seq_stop;
  logic       seq_jump;
  logic       dir_evt;
  logic       restart;
  logic       stopped_q;

  assign tick     = (state_q == SW_RUN) && (timer_q <= `RSQ_TIMER_ONE);
  assign at_final = addr_q == seg_rd.final_addr;
  assign seq_end  = int_act && tick && at_final;
  assign seq_stop = seq_end && !ipc[2] && (seq_prof_q == last_prof);
  assign seq_jump = seq_end && !seq_stop;
  // A profile pin change restarts only where profiles are live; bidirectional treats the low pin as direction.
  assign restart  = upd_rise || seq_jump || (ps_chg && ram_en && !int_act && !bidir);
  assign dir_evt  = bidir && dir_chg && (state_q == SW_RUN) && !restart;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_prof_q <= 2'h0;
    end else if (ce) begin
      if (upd_rise) begin
        seq_prof_q <= 2'h0;
      end else if (seq_jump) begin
        seq_prof_q <= (seq_prof_q == last_prof) ? 2'h0 : seq_prof_q + 2'h1;
      end
    end
  end

  // The extra load cycle lets the table read settle after the index moves.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= SW_IDLE;
      wait_q    <= 1'b0;
      stopped_q <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        state_q   <= SW_LOAD;
        wait_q    <= 1'b1;
        stopped_q <= 1'b0;
      end else begin
        unique case (state_q)
          SW_IDLE: begin
          end
          SW_LOAD: begin
            if (wait_q) begin
              wait_q <= 1'b0;
            end else begin
              state_q <= ram_en ? SW_RUN : SW_IDLE;
            end
          end
          SW_RUN: begin
            if (seq_stop) begin
              state_q   <= SW_STOP;
              stopped_q <= 1'b1;
            end
          end
          SW_STOP: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    addr_d = addr_q;
    up_d   = up_q;
    unique case (cur_mode)
      M_BIDIR: begin
        if (ps_s2_q[0]) begin
          if (!at_final) begin
            addr_d = addr_inc(addr_q);
          end
        end else if (addr_q != seg_rd.begin_addr) begin
          addr_d = addr_dec(addr_q);
        end
      end
      M_CBIDIR: begin
        if (up_q) begin
          up_d   = !at_final;
          addr_d = at_final ? addr_dec(addr_q) : addr_inc(addr_q);
        end else begin
          up_d   = addr_q == seg_rd.begin_addr;
          addr_d = up_d ? addr_inc(addr_q) : addr_dec(addr_q);
        end
      end
      M_RECIRC: begin
        addr_d = at_final ? seg_rd.begin_addr : addr_inc(addr_q);
      end
      M_RAMP_UP: begin
        if (!at_final) begin
          addr_d = addr_inc(addr_q);
        end
      end
      M_DIRECT: begin
        addr_d = addr_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= '0;
      up_q   <= 1'b1;
    end else if (ce) begin
      if (state_q == SW_LOAD && !wait_q && !restart) begin
        addr_q <= seg_rd.begin_addr;
        up_q   <= 1'b1;
      end else if ((tick || dir_evt) && !restart) begin
        addr_q <= addr_d;
        up_q   <= up_d;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_q <= '0;
    end else if (ce) begin
      if (state_q == SW_LOAD && !wait_q && !restart) begin
        timer_q <= seg_rd.rate;
      end else if (state_q == SW_RUN && !restart) begin
        timer_q <= (tick || dir_evt) ? seg_rd.rate : timer_q - `RSQ_TIMER_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  logic [31:0] status;
  logic        dest_q;
  logic [31:0] rdata_q;

  assign status = {16'h0000, state_q, stopped_q, up_q, mem_idx, addr_q};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dest_q <= 1'b0;
    end else if (ce) begin
      dest_q <= ctrl_act_q[`RSQ_CTRL_DEST];
    end
  end

  // Read data stand for exactly one cycle; unmapped reads return zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (!bus_read) begin
        rdata_q <= 32'h0000_0000;
      end else if (bus_addr == `RSQ_OFF_CTRL) begin
        rdata_q <= ctrl_buf_q;
      end else if (bus_addr == `RSQ_OFF_STATUS) begin
        rdata_q <= status;
      end else if (seg_hit(bus_addr)) begin
        rdata_q <= seg_buf_q[bus_addr[4:2]];
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign bus_rdata      = rdata_q;
  assign ram_addr       = addr_q;
  assign ram_dest_phase = dest_q;
  assign sweep_stopped  = stopped_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  a_update_copy: assert property (@(posedge clk) disable iff (!resetn || !ce)
    upd_rise |=> ctrl_act_q == $past(ctrl_buf_q)) else $error("update did not copy control");
  a_pin_no_update: assert property (@(posedge clk) disable iff (!resetn || !ce)
    !upd_rise |=> ctrl_act_q == $past(ctrl_act_q)) else $error("control changed without update");
  a_load_begin: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (state_q == SW_LOAD && !wait_q && !restart) |=>
      (addr_q == $past(seg_rd.begin_addr)) && (timer_q == $past(seg_rd.rate))) else $error("bad load");
  a_timer_count: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (state_q == SW_RUN && timer_q > `RSQ_TIMER_ONE && !dir_evt && !restart) |=>
      timer_q == $past(timer_q) - `RSQ_TIMER_ONE) else $error("timer did not count down");
  a_dir_step: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (dir_evt && ps_s2_q[0] && !at_final) |=>
      (addr_q == $past(addr_q) + `RSQ_ADDR_ONE) && (timer_q == $past(seg_rd.rate))) else $error("no step on dir");
  a_bidir_hold: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (cur_mode == M_BIDIR && tick && ps_s2_q[0] && at_final && !restart) |=>
      addr_q == $past(addr_q)) else $error("bidirectional passed final");
  a_cbidir_turn: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (cur_mode == M_CBIDIR && tick && up_q && at_final && !restart) |=> !up_q) else $error("no turn at final");
  a_recirc_wrap: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (cur_mode == M_RECIRC && tick && at_final && !restart) |=>
      addr_q == $past(seg_rd.begin_addr)) else $error("no wrap at final");
  a_internal_idx: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (int_act && ps_chg) |-> !restart || upd_rise || seq_jump) else $error("pins restarted internal mode");
  a_burst_stop: assert property (@(posedge clk) disable iff (!resetn || !ce)
    (state_q == SW_STOP && !restart) |=> state_q == SW_STOP && sweep_stopped) else $error("burst left stop");
  a_dest_route: assert property (@(posedge clk) disable iff (!resetn || !ce)
    upd_rise |=> ##1 ram_dest_phase == $past(ctrl_act_q[`RSQ_CTRL_DEST])) else $error("destination not routed");

endmodule // rsq_sequencer

/* rsq_host.sv */
// Host controller model that drives the profile-select pins and the update strobe.
`timescale 1ns/1ps
module rsq_host (
  input  wire logic clk,
  output      logic profile_select_low,
  output      logic profile_select_high,
  output      logic update_strobe
);
  initial begin
    profile_select_low  = 1'b0;
    profile_select_high = 1'b0;
    update_strobe       = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins move just after an edge and then stay put, as a real host's port latch would.
  task automatic set_pins(input logic [1:0] p);
    @(posedge clk);
    profile_select_high <= p[1];
    profile_select_low  <= p[0];
  endtask

  // The strobe is held for four cycles so the two-flop synchroniser cannot miss it.
  // The call returns while the sequencer is still loading, so the next address seen is the new begin.
  task automatic pulse_update();
    @(posedge clk);
    update_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    update_strobe <= 1'b0;
  endtask
endmodule // rsq_host

/* rsq_sequencer_tb_top.sv */
// Self-checking bench for the RAM sweep address sequencer, with a queue model of the address trail.
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_sequencer_tb_top;
  import rsq_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        profile_select_low;
  logic        profile_select_high;
  logic        update_strobe;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_write = 1'b0;
  logic        bus_read = 1'b0;
  logic [31:0] bus_rdata;
  rsq_addr_t   ram_addr;
  logic        ram_dest_phase;
  logic        sweep_stopped;
  int          mismatches = 0;
  int          n_compared = 0;
  rsq_addr_t   got[$];
  int          gaps[$];
  int          exp_q[$];

  always #12.5 clk = ~clk;

  rsq_sequencer uut (
    .clk                 (clk),
    .resetn              (resetn),
    .ce                  (ce),
    .profile_select_low  (profile_select_low),
    .profile_select_high (profile_select_high),
    .update_strobe       (update_strobe),
    .bus_addr            (bus_addr),
    .bus_wdata           (bus_wdata),
    .bus_write           (bus_write),
    .bus_read            (bus_read),
    .bus_rdata           (bus_rdata),
    .ram_addr            (ram_addr),
    .ram_dest_phase      (ram_dest_phase),
    .sweep_stopped       (sweep_stopped)
  );

  rsq_host host (
    .clk                 (clk),
    .profile_select_low  (profile_select_low),
    .profile_select_high (profile_select_high),
    .update_strobe       (update_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_read <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic prog(input int p, input int mode, input int b, input int f, input int rate);
    wr(8'h20 + 8'(8 * p), 32'(rate));
    wr(8'h24 + 8'(8 * p), 32'((f << `RSQ_SEG_FIN_LO) | (b << `RSQ_SEG_BEG_LO) | (mode << `RSQ_SEG_MODE_LO)));
  endtask

  // Records each new address and the cycles since the previous one, then compares with the model.
  task automatic grab();
    rsq_addr_t last;
    int        gap;
    got.delete();
    gaps.delete();
    #1;
    last = ram_addr;
    gap  = 0;
    while (got.size() < exp_q.size() && gap < 300) begin
      @(posedge clk);
      #1;
      gap++;
      if (ram_addr !== last) begin
        got.push_back(ram_addr);
        gaps.push_back(gap);
        last = ram_addr;
        gap  = 0;
      end
    end
    for (int i = 0; i < exp_q.size(); i++)
      chk("ram_addr trail", 32'(exp_q[i]), (i < got.size()) ? 32'(got[i]) : 32'hxxxx_xxxx);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    rsq_addr_t   hold;
    int          rate;
    void'($urandom(32'h4a6b));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk("ram_addr", 32'h0, 32'(ram_addr));
    chk("sweep_stopped", 32'h0, 32'(sweep_stopped));
    rd(8'h00, d);
    chk("ctrl reset", 32'h0, d);
    wr(8'h00, 32'hffff_ffff);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h00, d);
    chk("ctrl", 32'hf800_0000, d);
    rd(8'h24, d);
    chk("seg word", 32'h0fff_ffff, d);
    @(posedge clk);
    #1;
    chk("rdata idle", 32'h0, bus_rdata);
    rd(8'h1c, d);
    chk("unmapped", 32'h0, d);
    // Recirculation at a random rate, RAM output routed to the phase adder.
    rate = 1 + ($urandom % 4);
    prog(0, 4, 5, 7, rate);
    wr(8'h00, 32'hc000_0000);
    host.pulse_update();
    exp_q = '{5, 6, 7, 5, 6, 7};
    grab();
    for (int i = 1; i < gaps.size(); i++)
      chk("step gap", 32'(rate), 32'(gaps[i]));
    chk("dest", 32'h1, 32'(ram_dest_phase));
    @(posedge clk);
    ce <= 1'b0;
    #1;
    hold = ram_addr;
    repeat (10) @(posedge clk);
    #1;
    chk("frozen", 32'(hold), 32'(ram_addr));
    @(posedge clk);
    ce <= 1'b1;
    // Continuous bidirectional, then a profile pin switches to another segment.
    prog(0, 3, 10, 12, 1);
    prog(1, 3, 100, 102, 2);
    wr(8'h00, 32'h8000_0000);
    host.pulse_update();
    exp_q = '{10, 11, 12, 11, 10, 11, 12};
    grab();
    chk("dest", 32'h0, 32'(ram_dest_phase));
    host.set_pins(2'b01);
    repeat (3) @(posedge clk);
    exp_q = '{100, 101, 102, 101, 100};
    grab();
    // Bidirectional: the low pin steers, a buffered word must wait for a strobe edge.
    prog(0, 2, 200, 203, 6);
    host.pulse_update();
    exp_q = '{200, 201, 202, 203};
    grab();
    prog(0, 2, 210, 213, 6);
    repeat (30) @(posedge clk);
    #1;
    chk("hold at final", 32'd203, 32'(ram_addr));
    host.set_pins(2'b11);
    repeat (20) @(posedge clk);
    #1;
    chk("high pin ignored", 32'd203, 32'(ram_addr));
    host.set_pins(2'b10);
    exp_q = '{202, 201, 200};
    grab();
    chk("turn step", 32'd3, 32'(gaps[0]));
    chk("reload gap", 32'd6, 32'(gaps[1]));
    repeat (40) @(posedge clk);
    #1;
    chk("hold at begin", 32'd200, 32'(ram_addr));
    // Internal sequencing over field values 1 to 6; stored modes must be overridden.
    for (int p = 0; p < 4; p++)
      prog(p, (p == 3) ? 5 : 4, 16 * p + 16, 16 * p + 17, 1);
    for (int ipc = 1; ipc < 7; ipc++) begin
      host.set_pins(2'b11);
      wr(8'h00, 32'h8000_0000);
      host.pulse_update();
      repeat (12) @(posedge clk);
      #1;
      chk("direct switch", 32'd64, 32'(ram_addr));
      wr(8'h00, 32'h8000_0000 | 32'(ipc << `RSQ_CTRL_IPC_LO));
      exp_q.delete();
      for (int l = 0; l < ((ipc > 3) ? 2 : 1); l++)
        for (int p = 0; p < ((ipc > 3) ? ipc - 2 : ipc + 1); p++) begin
          exp_q.push_back(16 * p + 16);
          exp_q.push_back(16 * p + 17);
        end
      host.pulse_update();
      fork
        grab();
        begin
          repeat (10) @(posedge clk);
          repeat (5) begin
            host.set_pins(2'($urandom));
            repeat (3) @(posedge clk);
          end
        end
      join
      repeat (10) @(posedge clk);
      #1;
      chk("stopped", 32'(ipc < 4), 32'(sweep_stopped));
      if (ipc < 4)
        chk("burst end", 32'(exp_q[$]), 32'(ram_addr));
    end
    // Without RAM enable the internal field must not sequence anything.
    wr(8'h00, 32'h0800_0000);
    host.pulse_update();
    repeat (8) @(posedge clk);
    #1;
    hold = ram_addr;
    repeat (20) @(posedge clk);
    #1;
    chk("ram off holds", 32'(hold), 32'(ram_addr));
    chk("ram off no burst", 32'h0, 32'(sweep_stopped));
    tally_and_finish();
  end
endmodule // rsq_sequencer_tb_top
